// ===== design/mrp_map.svh
// register map, reset values and timing figures of the meter panel controller
`ifndef MRP_MAP_SVH
`define MRP_MAP_SVH
`define MRP_A_CFG 12'h000
`define MRP_A_OFS 12'h004
`define MRP_A_BAND 12'h008
`define MRP_A_CODE 12'h00c
`define MRP_A_STAT 12'h010
`define MRP_A_DISP 12'h014
`define MRP_A_MINMAX 12'h018
`define MRP_CFG_RST 16'hc093
`define MRP_OFS_RST 16'h0000
`define MRP_BAND_RST 8'h0a
`define MRP_BAND_MAX 8'hc7
`define MRP_CODE_RST 10'h000
`define MRP_INTEN_RST 3'h3
`define MRP_INTEN_MIN 3'h1
`define MRP_INTEN_MAX 3'h5
`define MRP_MINUS 4'ha
`define MRP_DIGIT_MAX 4'h9
`define MRP_CW 27
`define MRP_CLK_KHZ 25000
`define MRP_HOLD_MS 2000
`define MRP_SCROLL_MS 4000
`define MRP_REP_MS 250
`define MRP_ALT_MS 1000
`define MRP_MSG_MS 1000
`define MRP_PWR_CYC 4
`endif

// ===== design/mrp_pkg.sv
// types of the meter panel controller
`include "mrp_map.svh"
package mrp_pkg;
  typedef enum logic [5:0] {
    ST_PWR = 6'h01, ST_FACT = 6'h02, ST_DISP = 6'h04,
    ST_PROMPT = 6'h08, ST_PARAM = 6'h10, ST_EDIT = 6'h20
  } mrp_state_t;
  typedef enum logic [3:0] {
    UF_NONE, UF_LOCK, UF_RESET, UF_FREEZE, UF_DSEL, UF_INTEN,
    UF_COLOR, UF_PRINT, UF_PRTRST, UF_SP1, UF_SP2, UF_SP12
  } mrp_uif_t;
  typedef enum logic [3:0] {
    TC_T, TC_E, TC_J, TC_K, TC_R, TC_S, TC_B, TC_N, TC_MV
  } mrp_tc_t;
  typedef enum logic [2:0] {
    P_TYPE, P_CJC, P_SCALE, P_DP, P_OFS, P_FILT, P_BAND, P_UIF
  } mrp_param_t;
  typedef struct packed {
    logic rst_en, sel_en, scroll_en;
    mrp_uif_t uif;
    logic [1:0] filt;
    logic dp, scale, cjc;
    mrp_tc_t tc;
  } mrp_cfg_t;
  typedef struct packed {
    logic prog;
    logic [1:0] sp;
    logic ui;
    logic [1:0] dsel;
    mrp_state_t st;
  } mrp_stat_t;
  typedef struct packed {
    logic [2:0] s;
    logic db;
  } mrp_sync_t;
  typedef struct packed {
    mrp_state_t st;
    mrp_sync_t ki, kc, ui;
    logic [`MRP_CW-1:0] hold, rep, scrl, alt;
    logic held, prog, fmsg, show_name, mod_sel;
    mrp_cfg_t cfg;
    logic signed [15:0] ofs;
    logic [7:0] band;
    logic [9:0] code;
    mrp_param_t pidx;
    logic [1:0] dig;
    logic [15:0] bcd;
    logic signed [15:0] filt, disp, maxv, minv, shown;
    logic [1:0] dsel, sp_ind, sp_rst;
    logic nv_wr, prn, mm_rst, color, mv;
    logic [2:0] inten;
    logic [31:0] prdata;
    logic pready, pslverr;
  } mrp_st_t;
endpackage : mrp_pkg

// ===== design/mrp_top.sv
// panel keys, user input, readout filter and apb registers of the temperature meter
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Overview of operation
// - user input counts as asserted while its line is low, idle when pulled high.
// - display mode: index steps shown value, clear resets min/max or setpoint outputs.
// - holding index two seconds in display mode enters program mode.
// - with scrolling on, shown value advances every four seconds by itself.
// - setpoint indicators 1 and 2 light while the matching output is active.
// - no key edits in display mode; entry refused under code or lockout.
// - prompt alternates with module; clear steps module, index enters it.
// - parameter name and value alternate; clear cycles, index stores and advances.
// - numeric entry: clear edits and increments digit, index steps, hold stores.
// - index at module zero commits to nonvolatile memory and leaves program mode.
// - both keys held at power-up load defaults and show the restore message.
// - thermocouple type picks the curve; millivolt type shows raw input.
// - millivolt skips junction, scale, point; R, S, B skip the point.
// - signed offset from -999 to 9999 adds to the reading.
// - filter level 0 passes; 1, 2, 3 take 1/4, 1/8, 1/16 of new input.
// - filter bypasses while change exceeds band of up to 199, engages below.
// - band zero keeps the filter engaged always.
// - reset function loads assigned captures with current input on each assertion.
// - freeze holds the input display while asserted; all else keeps running.
// - each activation raises intensity one level, wrapping from 5 to 1, or swaps backlight colour.
// - print-and-reset requests a print and resets assigned values in the same cycle.
// - setpoint reset functions clear output 1, output 2, or both.
module mrp_top
  import mrp_pkg::*;
#(
  parameter logic [`MRP_CW-1:0] HOLD_CYC = `MRP_CW'(`MRP_HOLD_MS * `MRP_CLK_KHZ),
  parameter logic [`MRP_CW-1:0] SCROLL_CYC = `MRP_CW'(`MRP_SCROLL_MS * `MRP_CLK_KHZ),
  parameter logic [`MRP_CW-1:0] REP_CYC = `MRP_CW'(`MRP_REP_MS * `MRP_CLK_KHZ),
  parameter logic [`MRP_CW-1:0] ALT_CYC = `MRP_CW'(`MRP_ALT_MS * `MRP_CLK_KHZ),
  parameter logic [`MRP_CW-1:0] MSG_CYC = `MRP_CW'(`MRP_MSG_MS * `MRP_CLK_KHZ)
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic key_index_n,
  input wire logic key_clear_n,
  input wire logic user_input_n,
  input wire logic [1:0] sp_active,
  input wire logic sample_valid,
  input wire logic signed [15:0] sample_value,
  output logic signed [15:0] disp_value,
  output logic [1:0] disp_sel,
  output logic [1:0] sp_ind,
  output logic [1:0] sp_reset,
  output logic minmax_reset,
  output logic prog_mode,
  output logic show_name,
  output logic module_sel,
  output logic [2:0] param_sel,
  output logic [1:0] edit_digit,
  output logic [15:0] edit_bcd,
  output logic nv_write,
  output logic factory_restore_message,
  output logic print_req,
  output logic [2:0] intensity,
  output logic backlight_green,
  output logic [3:0] curve_sel,
  output logic show_mv
);
  mrp_st_t s;
  mrp_st_t n;
  mrp_sync_t n_ki, n_kc, n_ui;
  logic short_i, long_i, press_c, inc_c, ui_fall, ui_hold, ui_cap;
  logic eng, locked;
  logic signed [15:0] inval, nf;
  logic signed [16:0] diff, mag, step;
  logic [3:0] dv, dlim;

  function automatic mrp_sync_t sync_step(mrp_sync_t c, logic in);
    sync_step.s = {c.s[1:0], in};
    sync_step.db = (c.s[2] == c.s[1]) ? c.s[2] : c.db;
  endfunction : sync_step

  function automatic logic skip(mrp_param_t p, mrp_tc_t t);
    skip = ((p == P_CJC || p == P_SCALE || p == P_DP) && t == TC_MV) ||
      (p == P_DP && (t == TC_R || t == TC_S || t == TC_B));
  endfunction : skip

  function automatic mrp_param_t nxt(mrp_param_t p, mrp_tc_t t);
    logic [2:0] q;
    q = 3'(p + 3'h1);
    for (int i = 0; i < 3; i++)
      if (skip(mrp_param_t'(q), t))
        q = 3'(q + 3'h1);
    nxt = mrp_param_t'(q);
  endfunction : nxt

  function automatic logic signed [15:0] bcd2bin(logic [15:0] b);
    logic [15:0] lo;
    lo = 16'(b[11:8] * 7'd100 + b[7:4] * 4'd10 + b[3:0]);
    if (b[15:12] == `MRP_MINUS)
      bcd2bin = -$signed(lo);
    else
      bcd2bin = $signed(16'(lo + b[15:12] * 10'd1000));
  endfunction : bcd2bin

  function automatic logic [1:0] step_sel(logic [1:0] d);
    step_sel = (d == 2'h2) ? 2'h0 : 2'(d + 2'h1);
  endfunction : step_sel

  always_comb
  begin
    n = s;
    n_ki = sync_step(s.ki, ~key_index_n);
    n_kc = sync_step(s.kc, ~key_clear_n);
    n_ui = sync_step(s.ui, ~user_input_n);
    n.ki = n_ki;
    n.kc = n_kc;
    n.ui = n_ui;
    n.nv_wr = 1'b0;
    n.prn = 1'b0;
    n.mm_rst = 1'b0;
    n.sp_rst = 2'h0;
    n.sp_ind = sp_active;
    press_c = n_kc.db & ~s.kc.db;
    short_i = ~n_ki.db & s.ki.db & ~s.held;
    long_i = 1'b0;
    inc_c = press_c;
    // index hold timer; a long hold fires once and swallows the release
    if (n_ki.db)
    begin
      if (!s.held && s.hold == HOLD_CYC - 1'b1)
      begin
        long_i = 1'b1;
        n.held = 1'b1;
      end
      n.hold = s.held ? s.hold : `MRP_CW'(s.hold + 1'b1);
    end
    else
    begin
      n.hold = '0;
      n.held = 1'b0;
    end
    if (n_kc.db && !press_c)
    begin
      if (s.rep == REP_CYC - 1'b1)
      begin
        n.rep = '0;
        inc_c = (s.st == ST_EDIT);
      end
      else
        n.rep = `MRP_CW'(s.rep + 1'b1);
    end
    else
      n.rep = '0;
    // readout path: offset, then adaptive filter
    inval = 16'(sample_value + s.ofs);
    diff = {inval[15], inval} - {s.filt[15], s.filt};
    mag = diff[16] ? -diff : diff;
    eng = (s.cfg.filt != 2'h0) &&
      (s.band == 8'h0 || mag <= $signed({9'h0, s.band}));
    step = diff >>> ({1'b0, s.cfg.filt} + 3'h1);
    nf = eng ? 16'({s.filt[15], s.filt} + step) : inval;
    ui_hold = (s.cfg.uif == UF_FREEZE) && s.ui.db;
    if (sample_valid)
    begin
      n.filt = nf;
      if (!ui_hold)
        n.disp = nf;
      if (nf > s.maxv)
        n.maxv = nf;
      if (nf < s.minv)
        n.minv = nf;
    end
    // user input edge functions act only on the asserting edge
    ui_fall = n_ui.db & ~s.ui.db;
    ui_cap = 1'b0;
    if (ui_fall)
    begin
      unique case (s.cfg.uif)
        UF_RESET: ui_cap = 1'b1;
        UF_DSEL: n.dsel = step_sel(s.dsel);
        UF_INTEN: n.inten = (s.inten >= `MRP_INTEN_MAX) ? `MRP_INTEN_MIN : 3'(s.inten + 3'h1);
        UF_COLOR: n.color = ~s.color;
        UF_PRINT: n.prn = 1'b1;
        UF_PRTRST:
        begin
          n.prn = 1'b1;
          ui_cap = 1'b1;
        end
        UF_SP1: n.sp_rst = 2'h1;
        UF_SP2: n.sp_rst = 2'h2;
        UF_SP12: n.sp_rst = 2'h3;
        default: ;
      endcase
    end
    locked = (s.code != 10'h0) || (s.cfg.uif == UF_LOCK && s.ui.db);
    if (s.st == ST_PROMPT || s.st == ST_PARAM)
    begin
      if (s.alt == ALT_CYC - 1'b1)
      begin
        n.alt = '0;
        n.show_name = ~s.show_name;
      end
      else
        n.alt = `MRP_CW'(s.alt + 1'b1);
    end
    dv = s.bcd[{s.dig, 2'b00} +: 4];
    dlim = (s.pidx == P_OFS && s.dig == 2'h3) ? `MRP_MINUS : `MRP_DIGIT_MAX;
    unique case (s.st)
      ST_PWR:
      begin
        n.alt = `MRP_CW'(s.alt + 1'b1);
        if (s.alt == `MRP_CW'(`MRP_PWR_CYC))
        begin
          n.alt = '0;
          n.held = 1'b1;
          if (s.ki.db && s.kc.db)
          begin
            n.st = ST_FACT;
            n.fmsg = 1'b1;
            n.cfg = `MRP_CFG_RST;
            n.ofs = `MRP_OFS_RST;
            n.band = `MRP_BAND_RST;
            n.code = `MRP_CODE_RST;
            n.nv_wr = 1'b1;
          end
          else
            n.st = ST_DISP;
        end
      end
      ST_FACT:
      begin
        n.alt = `MRP_CW'(s.alt + 1'b1);
        if (s.alt == MSG_CYC - 1'b1)
        begin
          n.alt = '0;
          n.fmsg = 1'b0;
          n.st = ST_DISP;
        end
      end
      ST_DISP:
      begin
        if (short_i && s.cfg.sel_en)
          n.dsel = step_sel(s.dsel);
        if (press_c && s.cfg.rst_en)
        begin
          if (s.dsel == 2'h0)
            n.sp_rst = 2'h3;
          else
            ui_cap = 1'b1;
        end
        if (s.cfg.scroll_en && !s.ki.db)
        begin
          if (s.scrl == SCROLL_CYC - 1'b1)
          begin
            n.scrl = '0;
            n.dsel = step_sel(s.dsel);
          end
          else
            n.scrl = `MRP_CW'(s.scrl + 1'b1);
        end
        else
          n.scrl = '0;
        if (long_i && !locked)
        begin
          n.st = ST_PROMPT;
          n.prog = 1'b1;
          n.mod_sel = 1'b0;
          n.show_name = 1'b1;
          n.alt = '0;
        end
      end
      ST_PROMPT:
      begin
        if (press_c)
          n.mod_sel = ~s.mod_sel;
        if (short_i && !s.mod_sel)
        begin
          n.nv_wr = 1'b1;
          n.st = ST_DISP;
          n.prog = 1'b0;
          n.scrl = '0;
        end
        else if (short_i)
        begin
          n.st = ST_PARAM;
          n.pidx = nxt(P_UIF, s.cfg.tc);
          n.alt = '0;
          n.show_name = 1'b1;
        end
      end
      ST_PARAM:
      begin
        if (press_c)
        begin
          unique case (s.pidx)
            P_TYPE: n.cfg.tc = (s.cfg.tc >= TC_MV) ? TC_T : mrp_tc_t'(4'(s.cfg.tc + 4'h1));
            P_CJC: n.cfg.cjc = ~s.cfg.cjc;
            P_SCALE: n.cfg.scale = ~s.cfg.scale;
            P_DP: n.cfg.dp = ~s.cfg.dp;
            P_FILT: n.cfg.filt = 2'(s.cfg.filt + 2'h1);
            P_UIF: n.cfg.uif = (s.cfg.uif >= UF_SP12) ? UF_NONE : mrp_uif_t'(4'(s.cfg.uif + 4'h1));
            default:
            begin
              n.st = ST_EDIT;
              n.dig = 2'h0;
              n.bcd = 16'h0000;
              n.show_name = 1'b0;
            end
          endcase
        end
        else if (short_i)
        begin
          n.alt = '0;
          n.show_name = 1'b1;
          if (s.pidx == P_UIF)
          begin
            n.st = ST_PROMPT;
            n.mod_sel = 1'b0;
          end
          else
            n.pidx = nxt(s.pidx, s.cfg.tc);
        end
      end
      ST_EDIT:
      begin
        if (inc_c)
          n.bcd[{s.dig, 2'b00} +: 4] = (dv >= dlim) ? 4'h0 : 4'(dv + 4'h1);
        if (short_i)
          n.dig = 2'(s.dig + 2'h1);
        if (long_i)
        begin
          if (s.pidx == P_OFS)
            n.ofs = bcd2bin(s.bcd);
          else
            n.band = (bcd2bin(s.bcd) > $signed({8'h0, `MRP_BAND_MAX})) ?
              `MRP_BAND_MAX : 8'(bcd2bin(s.bcd));
          n.pidx = nxt(s.pidx, s.cfg.tc);
          n.st = ST_PARAM;
          n.show_name = 1'b1;
          n.alt = '0;
        end
      end
    endcase
    if (ui_cap)
    begin
      n.mm_rst = 1'b1;
      n.maxv = inval;
      n.minv = inval;
    end
    n.shown = (n.dsel == 2'h1) ? n.maxv : (n.dsel == 2'h2) ? n.minv : n.disp;
    // registered with the type so the millivolt flag leaves from a flop
    n.mv = (n.cfg.tc == TC_MV);
    // apb slave, answers in the first access cycle
    n.pready = psel & ~penable;
    if (psel && !penable)
    begin
      n.pslverr = 1'b0;
      n.prdata = 32'h0;
      unique case (paddr)
        `MRP_A_CFG: n.prdata = {16'h0, s.cfg};
        `MRP_A_OFS: n.prdata = {{16{s.ofs[15]}}, s.ofs};
        `MRP_A_BAND: n.prdata = {24'h0, s.band};
        `MRP_A_CODE: n.prdata = {22'h0, s.code};
        `MRP_A_STAT: n.prdata = {20'h0, mrp_stat_t'({s.prog, s.sp_ind, s.ui.db, s.dsel, s.st})};
        `MRP_A_DISP: n.prdata = {{16{s.shown[15]}}, s.shown};
        `MRP_A_MINMAX: n.prdata = {s.minv, s.maxv};
        default: n.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && s.pready && pwrite)
    begin
      unique case (paddr)
        `MRP_A_CFG: n.cfg = mrp_cfg_t'(pwdata[15:0]);
        `MRP_A_OFS: n.ofs = pwdata[15:0];
        `MRP_A_BAND: n.band = (pwdata[7:0] > `MRP_BAND_MAX) ? `MRP_BAND_MAX : pwdata[7:0];
        `MRP_A_CODE: n.code = pwdata[9:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.st <= ST_PWR;
      s.held <= 1'b1;
      s.cfg <= `MRP_CFG_RST;
      s.ofs <= `MRP_OFS_RST;
      s.band <= `MRP_BAND_RST;
      s.inten <= `MRP_INTEN_RST;
    end
    else
      s <= n;
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign disp_value = s.shown;
  assign disp_sel = s.dsel;
  assign sp_ind = s.sp_ind;
  assign sp_reset = s.sp_rst;
  assign minmax_reset = s.mm_rst;
  assign prog_mode = s.prog;
  assign show_name = s.show_name;
  assign module_sel = s.mod_sel;
  assign param_sel = s.pidx;
  assign edit_digit = s.dig;
  assign edit_bcd = s.bcd;
  assign nv_write = s.nv_wr;
  assign factory_restore_message = s.fmsg;
  assign print_req = s.prn;
  assign intensity = s.inten;
  assign backlight_green = s.color;
  assign curve_sel = s.cfg.tc;
  assign show_mv = s.mv;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ui_low_active: assert property ((!user_input_n)[*5] |=> s.ui.db)
    else $error("user input low not seen as asserted");
  chk_prog_hold: assert property ($rose(s.st == ST_PROMPT) && $past(s.st) == ST_DISP
    |-> $past(s.hold) == HOLD_CYC - 1'b1)
    else $error("program entry without full hold");
  chk_lock_refuse: assert property (s.st == ST_DISP && s.code != 10'h0
    |=> s.st != ST_PROMPT)
    else $error("program entry despite security code");
  chk_exit_commit: assert property (s.st == ST_PROMPT && !s.mod_sel && short_i
    |=> s.nv_wr && s.st == ST_DISP && !s.prog)
    else $error("exit at module zero did not commit");
  chk_filter_pass: assert property (sample_valid && s.cfg.filt == 2'h0
    |=> s.filt == $past(inval))
    else $error("level zero filter altered input");
  chk_band_bypass: assert property (sample_valid && s.band != 8'h0
    && mag > $signed({9'h0, s.band}) |=> s.filt == $past(inval))
    else $error("filter did not bypass large change");
  chk_band_zero: assert property (sample_valid && s.band == 8'h0 && s.cfg.filt != 2'h0
    && mag >= 17'sd32 |=> s.filt != $past(inval))
    else $error("zero band filter disengaged");
  chk_freeze_hold: assert property (ui_hold ##1 ui_hold |-> $stable(s.disp))
    else $error("frozen display changed");
  chk_sp_both: assert property (ui_fall && s.cfg.uif == UF_SP12 |=> s.sp_rst == 2'h3)
    else $error("setpoint reset not issued");
  chk_edge_once: assert property (s.sp_rst != 2'h0 && s.ui.db && $stable(s.cfg)
    |=> s.sp_rst == 2'h0 || s.st == ST_DISP)
    else $error("edge function repeated");
  chk_factory_load: assert property ($rose(s.st == ST_FACT)
    |-> s.cfg == `MRP_CFG_RST && s.fmsg)
    else $error("factory restore incomplete");
  chk_sp_lamp: assert property (##1 s.sp_ind == $past(sp_active))
    else $error("setpoint indicator lags");

  cov_prog_entry: cover property (s.st == ST_DISP ##1 s.st == ST_PROMPT);
  cov_commit: cover property (s.nv_wr && s.st == ST_DISP);
  cov_factory: cover property ($rose(s.fmsg));
  cov_edit_store: cover property (s.st == ST_EDIT ##1 s.st == ST_PARAM);
endmodule : mrp_top

// ===== sim/mrp_panel_model.sv
// model of the two front keys and the external user input switch
`timescale 1ns/1ps
module mrp_panel_model (
  input wire logic pclk,
  input wire logic [2:0] push,
  output logic key_index_n,
  output logic key_clear_n,
  output logic user_input_n
);
  // an open contact leaves the line at its pull-up level
  initial
  begin
    key_index_n = 1'b1;
    key_clear_n = 1'b1;
    user_input_n = 1'b1;
  end
  always @(posedge pclk)
  begin
    key_index_n <= !push[0];
    key_clear_n <= !push[1];
    user_input_n <= !push[2];
  end
endmodule : mrp_panel_model

// ===== sim/testbench.sv
// self-checking bench of the meter panel controller
`timescale 1ns/1ps
module testbench;
  import mrp_pkg::*;
  localparam int HC = 30;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, key_index_n, key_clear_n, user_input_n;
  logic [2:0] push = 3'h3;
  logic [1:0] sp_active = 2'h0;
  logic sample_valid = 1'b0;
  logic signed [15:0] sample_value = 16'h0;
  logic signed [15:0] disp_value;
  logic [1:0] disp_sel, sp_ind, sp_reset, edit_digit;
  logic [15:0] edit_bcd;
  logic minmax_reset, prog_mode, module_sel, nv_write, factory_restore_message;
  logic print_req, backlight_green, show_mv, show_name;
  logic [2:0] param_sel, intensity;
  logic [3:0] curve_sel;
  int error_cnt = 0;
  int n_compared = 0;
  int n_nv = 0;
  int n_s1 = 0;
  int n_s2 = 0;
  int n_pr = 0;
  int n_mm = 0;
  int prv, ofs, nw, k, sn[5];
  logic [31:0] rst_tab [5] = '{32'hc093, 32'h0, 32'h0a, 32'h0, 32'h4};
  mrp_uif_t uf_tab [8] = '{UF_SP1, UF_SP2, UF_SP12, UF_PRINT, UF_RESET, UF_PRTRST,
    UF_INTEN, UF_COLOR};
  int p_tab [4] = '{4, 5, 6, 7};
  mrp_top #(.HOLD_CYC(HC), .SCROLL_CYC(40), .REP_CYC(20), .ALT_CYC(20), .MSG_CYC(20)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_index_n(key_index_n), .key_clear_n(key_clear_n), .user_input_n(user_input_n),
    .sp_active(sp_active), .sample_valid(sample_valid), .sample_value(sample_value),
    .disp_value(disp_value), .disp_sel(disp_sel), .sp_ind(sp_ind), .sp_reset(sp_reset),
    .minmax_reset(minmax_reset), .prog_mode(prog_mode), .show_name(show_name),
    .module_sel(module_sel), .param_sel(param_sel), .edit_digit(edit_digit),
    .edit_bcd(edit_bcd),
    .nv_write(nv_write), .factory_restore_message(factory_restore_message),
    .print_req(print_req), .intensity(intensity), .backlight_green(backlight_green),
    .curve_sel(curve_sel), .show_mv(show_mv)
  );
  mrp_panel_model u_panel (
    .pclk(pclk), .push(push), .key_index_n(key_index_n), .key_clear_n(key_clear_n),
    .user_input_n(user_input_n)
  );
  always #20 pclk = ~pclk;
  // pulses are counted at the falling edge, where registered outputs are settled
  always @(negedge pclk)
  begin
    n_nv += int'(nv_write === 1'b1);
    n_s1 += int'(sp_reset[0] === 1'b1);
    n_s2 += int'(sp_reset[1] === 1'b1);
    n_pr += int'(print_req === 1'b1);
    n_mm += int'(minmax_reset === 1'b1);
  end
  function automatic int flt(int p, int n, int lvl);
    return (lvl == 0) ? n : p + ((n - p) >>> (lvl + 1));
  endfunction : flt
  function automatic logic [31:0] cfg(int tc, int fl, int uf);
    return 32'h0000c000 | 32'(tc) | 32'(fl << 7) | 32'(uf << 9);
  endfunction : cfg
  task automatic end_of_test;
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is taken at the rising edge, before the design's flops update
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic act(input int b, input int len);
    @(posedge pclk);
    push[b] <= 1'b1;
    repeat (len) @(posedge pclk);
    push[b] <= 1'b0;
    repeat (12) @(posedge pclk);
    @(negedge pclk);
  endtask : act
  task automatic samp(input int v);
    @(posedge pclk);
    sample_valid <= 1'b1;
    sample_value <= 16'(v);
    @(posedge pclk);
    sample_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask : samp
  initial
  begin
    #(40ns * 40000);
    error_cnt++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(43530));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(negedge pclk);
    chk(factory_restore_message, 1);
    @(posedge pclk);
    push <= 3'h0;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(rd, rst_tab[i]);
    end
    apb(1'b0, 12'h020, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, 12'h008, 32'hff);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'hc7);
    for (int t = 0; t < 9; t++)
    begin
      apb(1'b1, 12'h000, cfg(t, 0, 0));
      repeat (3) @(negedge pclk);
      chk({curve_sel, show_mv}, {t[3:0], t == 8});
    end
    repeat (16)
    begin
      k = $urandom_range(3);
      @(posedge pclk);
      sp_active <= 2'(k);
      @(negedge pclk);
      @(negedge pclk);
      chk(sp_ind, k);
    end
    // offset and samples stay small so no sum overflows the 16-bit readout
    ofs = int'($urandom_range(1998)) - 999;
    apb(1'b1, 12'h004, 32'(ofs));
    apb(1'b1, 12'h008, 32'h0);
    prv = 0;
    for (int l = 0; l < 4; l++)
    begin
      apb(1'b1, 12'h000, cfg(3, l, 0));
      repeat (4)
      begin
        nw = int'($urandom_range(4000)) - 2000;
        samp(nw);
        prv = flt(prv, nw + ofs, l);
        chk(disp_value, prv);
      end
    end
    apb(1'b1, 12'h008, 32'd10);
    nw = prv + 500 - ofs;
    samp(nw);
    prv = nw + ofs;
    chk(disp_value, prv);
    samp(nw + 8);
    prv = flt(prv, nw + 8 + ofs, 3);
    chk(disp_value, prv);
    apb(1'b1, 12'h000, cfg(3, 0, UF_FREEZE));
    @(posedge pclk);
    push[2] <= 1'b1;
    repeat (8) @(posedge pclk);
    samp(nw + 300);
    chk(disp_value, prv);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd[8], 1);
    @(posedge pclk);
    push[2] <= 1'b0;
    foreach (uf_tab[i])
    begin
      apb(1'b1, 12'h000, cfg(3, 0, uf_tab[i]));
      sn = '{n_s1, n_s2, n_pr, n_mm, int'(intensity)};
      k = int'(backlight_green);
      act(2, 40);
      chk(n_s1 - sn[0], uf_tab[i] inside {UF_SP1, UF_SP12});
      chk(n_s2 - sn[1], uf_tab[i] inside {UF_SP2, UF_SP12});
      chk(n_pr - sn[2], uf_tab[i] inside {UF_PRINT, UF_PRTRST});
      chk(n_mm - sn[3], uf_tab[i] inside {UF_RESET, UF_PRTRST});
      chk(intensity, sn[4] + (uf_tab[i] == UF_INTEN));
      chk(backlight_green, k ^ (uf_tab[i] == UF_COLOR));
    end
    apb(1'b1, 12'h000, cfg(3, 0, 0));
    sn = '{n_s1, n_s2, 0, 0, 0};
    act(1, 8);
    chk(n_s1 - sn[0], 1);
    chk(n_s2 - sn[1], 1);
    act(0, 8);
    chk(disp_sel, 1);
    apb(1'b1, 12'h00c, 32'd5);
    act(0, HC + 10);
    chk(prog_mode, 0);
    apb(1'b1, 12'h00c, 32'h0);
    act(0, HC - 12);
    chk(prog_mode, 0);
    apb(1'b1, 12'h000, cfg(8, 0, 0));
    act(0, HC + 10);
    chk({prog_mode, module_sel}, 2'b10);
    k = int'(show_name);
    repeat (20) @(negedge pclk);
    chk(show_name, !k[0]);
    act(1, 8);
    chk(module_sel, 1);
    act(0, 8);
    chk(param_sel, 0);
    foreach (p_tab[i])
    begin
      act(0, 8);
      chk(param_sel, p_tab[i]);
    end
    act(0, 8);
    chk({prog_mode, module_sel}, 2'b10);
    k = n_nv;
    act(0, 8);
    chk(n_nv - k, 1);
    chk(prog_mode, 0);
    // numeric entry of the offset: one tap, one auto-repeat, next digit, one tap
    act(0, HC + 10);
    act(1, 8);
    act(0, 8);
    act(0, 8);
    act(1, 8);
    act(1, HC);
    act(0, 8);
    act(1, 8);
    chk({edit_digit, edit_bcd}, 18'h10012);
    act(0, HC + 10);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'd12);
    chk(param_sel, 5);
    repeat (4) act(0, 8);
    chk(prog_mode, 0);
    apb(1'b1, 12'h000, cfg(3, 0, 0) | 32'h2000);
    k = int'(disp_sel);
    repeat (45) @(negedge pclk);
    chk(disp_sel, (k == 2) ? 0 : k + 1);
    end_of_test();
  end
endmodule : testbench
